// ===== rtl/tomh_axil_slv.sv
// AXI4-Lite slave front end of the operating message handler
`timescale 1ns/1ns
`default_nettype none
module tomh_axil_slv
   import tomh_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   tomh_reg_if.bus          rif
);
   logic        aw_full_q;
   logic        w_full_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic        w_b0_q;
   tomh_rd_st_t rd_st_q;

   // ***************************************
   // Write path: address and data in either order
   // ***************************************
   assign awready     = ce & ~aw_full_q & ~bvalid;
   assign wready      = ce & ~w_full_q & ~bvalid;
   assign rif.wr_en   = ce & aw_full_q & w_full_q & ~bvalid;
   assign rif.wr_addr = aw_addr_q;
   assign rif.wr_data = w_data_q;
   assign rif.wr_b0   = w_b0_q;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_b0_q    <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= 2'h0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_full_q <= 1'b1;
            w_data_q <= wdata;
            w_b0_q   <= wstrb[0];
         end
         if (rif.wr_en) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid    <= 1'b1;
            bresp     <= rif.wr_err ? 2'h2 : 2'h0;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ***************************************
   // Read path: one cycle to data
   // ***************************************
   assign arready     = ce & (rd_st_q == TOMH_RD_IDLE);
   assign rif.rd_en   = arvalid & arready;
   assign rif.rd_addr = araddr;
   assign rvalid      = (rd_st_q == TOMH_RD_RESP);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_st_q <= TOMH_RD_IDLE;
         rdata   <= 32'h0000_0000;
         rresp   <= 2'h0;
      end else if (ce) begin
         case (rd_st_q)
            TOMH_RD_IDLE: begin
               if (rif.rd_en) begin
                  rdata   <= rif.rd_data;
                  rresp   <= rif.rd_err ? 2'h2 : 2'h0;
                  rd_st_q <= TOMH_RD_RESP;
               end
            end
            TOMH_RD_RESP: begin
               if (rready) begin
                  rd_st_q <= TOMH_RD_IDLE;
               end
            end
            default: begin
               rd_st_q <= TOMH_RD_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== rtl/tomh_params.svh
// Constants of the operating message handler: offsets, fields, resets, timing
`ifndef TOMH_PARAMS_SVH
`define TOMH_PARAMS_SVH

// ***************************************
// Message type codes
// ***************************************
`define TOMH_TYPE_OP   8'h03
`define TOMH_TYPE_NAV  8'h04

// ***************************************
// Operating message payload fields
// ***************************************
`define TOMH_F_MODE    1:0
`define TOMH_F_ES      2
`define TOMH_F_PUS     3
`define TOMH_F_IDENT   4
`define TOMH_F_EMG     7:5
`define TOMH_F_SQK     19:8
`define TOMH_F_SQKV    20
`define TOMH_F_VRV     21
`define TOMH_F_VR      31:22
`define TOMH_F_NAVVR   9:0

// ***************************************
// Mode and emergency codes
// ***************************************
`define TOMH_MODE_OFF  2'h0
`define TOMH_MODE_STBY 2'h1
`define TOMH_MODE_ON   2'h2
`define TOMH_MODE_ALT  2'h3
`define TOMH_EMG_NONE  3'h0

// ***************************************
// Register offsets and interrupt bits
// ***************************************
`define TOMH_OFS_CTRL  8'h00
`define TOMH_OFS_STAT  8'h04
`define TOMH_OFS_ISTAT 8'h08
`define TOMH_OFS_ICLR  8'h0c
`define TOMH_OFS_IEN   8'h10
`define TOMH_OFS_VRATE 8'h14
`define TOMH_IRQ_OP    0
`define TOMH_IRQ_NAV   1
`define TOMH_IRQ_OTH   2
`define TOMH_IRQ_IDEND 3
`define TOMH_IRQ_STORE 4
`define TOMH_IRQ_W     5

// ***************************************
// Reset values
// ***************************************
`define TOMH_RST_OP    32'h0000_0000
`define TOMH_RST_CTRL  1'h0
`define TOMH_SQK_DFLT  12'h200

// ***************************************
// Timing
// ***************************************
`define TOMH_CLK_HZ    250000000
`define TOMH_IDENT_S   18
`define TOMH_IDENT_CYC (64'(`TOMH_IDENT_S) * 64'(`TOMH_CLK_HZ))

`endif

// ===== rtl/tomh_pkg.sv
// Types of the operating message handler
package tomh_pkg;
   typedef logic [1:0]  tomh_mode_t;
   typedef logic [2:0]  tomh_emg_t;
   typedef logic [11:0] tomh_sqk_t;
   typedef logic [9:0]  tomh_vr_t;
   typedef enum {TOMH_RD_IDLE, TOMH_RD_RESP} tomh_rd_st_t;
endpackage

// ===== rtl/tomh_reg_if.sv
// Register access carrier between the bus slave and the handler core
`timescale 1ns/1ns
`default_nettype none
interface tomh_reg_if;
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic        wr_b0;
   logic        wr_err;
   logic        rd_en;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_err;
   modport bus  (output wr_en, wr_addr, wr_data, wr_b0, rd_en, rd_addr,
                 input  wr_err, rd_data, rd_err);
   modport regs (input  wr_en, wr_addr, wr_data, wr_b0, rd_en, rd_addr,
                 output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// ===== rtl/tomh_top.sv
// Operating message handler core with register file and interrupt
`include "tomh_params.svh"
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Every received message is answered with an acknowledgement.
// - Off mode stops transmit and receive and enters low power.
// - Standby stops all transmit but keeps traffic reception.
// - Receiver self-test failures are not annunciated in standby.
// - On mode transponds but never reports pressure altitude.
// - Altitude mode is fully active, reporting altitude when available.
// - Extended-squitter flag set enables DF17 squitters.
// - Flag clear stops DF17; DF11 and targeted reception continue.
// - Store bit saves settings; power-up restores the latest stored ones.
// - Ident runs 18 seconds and restarts on each new request.
// - Emergency field selects none or one of seven emergency conditions.
// - Discrete low: valid message squawk, else code 1000.
// - Discrete high: valid civil squawk, else code 1000.
// - Message vertical rate when supplied, else navigation vertical rate.
module tomh_top
   import tomh_pkg::*;
#(
   parameter logic [32:0] IDENT_CYC = 33'(`TOMH_IDENT_CYC)
)(
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic        msg_valid,
   output logic             msg_ready,
   input  wire logic [7:0]  msg_type,
   input  wire logic [31:0] msg_data,
   output logic             ack_valid,
   output logic [7:0]       ack_type,
   input  wire logic [31:0] nvm_rdata,
   input  wire logic        nvm_rvalid,
   output logic             nvm_wr,
   output logic [31:0]      nvm_wdata,
   input  wire logic        usr_sqk_en,
   input  wire logic [11:0] civ_sqk,
   input  wire logic        civ_sqk_valid,
   input  wire logic        tgt_req_seen,
   input  wire logic        alt_avail,
   input  wire logic        rx_selftest_fail,
   output logic             tx_en,
   output logic             rx_en,
   output logic             adsb_in_en,
   output logic             low_power,
   output logic             alt_rpt_en,
   output logic             df17_en,
   output logic             df11_en,
   output logic             selftest_annunc,
   output logic             ident_active,
   output tomh_emg_t        emergency,
   output tomh_sqk_t        squawk,
   output tomh_vr_t         vrate,
   output logic             irq,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready
);
   if (IDENT_CYC == 33'h0) begin : g_chk
      $error("IDENT_CYC must be at least one cycle");
   end

   tomh_reg_if rif ();

   logic [31:0]          op_q;
   tomh_vr_t             nav_vr_q;
   logic                 boot_done_q;
   logic                 ctrl_off_q;
   logic [32:0]          ident_cnt_q;
   logic [`TOMH_IRQ_W-1:0] istat_q;
   logic [`TOMH_IRQ_W-1:0] ien_q;
   logic [`TOMH_IRQ_W-1:0] ev;
   logic                 take;
   logic                 take_op;
   logic                 take_nav;
   tomh_mode_t           mode;

   // ***************************************
   // Squawk selection
   // ***************************************
   function automatic tomh_sqk_t sel_sqk(input logic usr, input logic op_v,
                                         input tomh_sqk_t op_s, input logic cv,
                                         input tomh_sqk_t cs);
      tomh_sqk_t r;
      r = `TOMH_SQK_DFLT;
      if (usr) begin
         if (cv) r = cs;
      end else if (op_v) begin
         r = op_s;
      end
      return r;
   endfunction

   // ***************************************
   // Message intake and acknowledgement
   // ***************************************
   // One message per enabled cycle; decoding never stalls the host
   assign msg_ready = ce & ~srst;
   assign take      = msg_valid & msg_ready;
   assign take_op   = take & (msg_type == `TOMH_TYPE_OP);
   assign take_nav  = take & (msg_type == `TOMH_TYPE_NAV);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ack_valid <= 1'b0;
         ack_type  <= 8'h00;
      end else if (ce) begin
         ack_valid <= take;
         if (take) ack_type <= msg_type;
      end
   end

   // ***************************************
   // Settings store and power-up restore
   // ***************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         op_q        <= `TOMH_RST_OP;
         nav_vr_q    <= 10'h000;
         boot_done_q <= 1'b0;
         nvm_wr      <= 1'b0;
         nvm_wdata   <= 32'h0000_0000;
      end else if (ce) begin
         nvm_wr <= take_op & msg_data[`TOMH_F_PUS];
         if (take_op) begin
            op_q        <= msg_data;
            boot_done_q <= 1'b1;
            if (msg_data[`TOMH_F_PUS]) nvm_wdata <= msg_data;
         end else if (nvm_rvalid && !boot_done_q) begin
            // A live message always beats a late restore
            op_q        <= nvm_rdata;
            boot_done_q <= 1'b1;
         end
         if (take_nav) nav_vr_q <= msg_data[`TOMH_F_NAVVR];
      end
   end

   // ***************************************
   // Ident interval
   // ***************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ident_cnt_q <= 33'h0;
      end else if (ce) begin
         if (take_op && msg_data[`TOMH_F_IDENT]) begin
            ident_cnt_q <= IDENT_CYC;
         end else if (ident_cnt_q != 33'h0) begin
            ident_cnt_q <= ident_cnt_q - 33'h1;
         end
      end
   end

   // ***************************************
   // Mode decode to registered controls
   // ***************************************
   assign mode = ctrl_off_q ? `TOMH_MODE_OFF : op_q[`TOMH_F_MODE];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tx_en           <= 1'b0;
         rx_en           <= 1'b0;
         adsb_in_en      <= 1'b0;
         low_power       <= 1'b1;
         alt_rpt_en      <= 1'b0;
         df17_en         <= 1'b0;
         df11_en         <= 1'b0;
         selftest_annunc <= 1'b0;
         ident_active    <= 1'b0;
         emergency       <= `TOMH_EMG_NONE;
         squawk          <= `TOMH_SQK_DFLT;
         vrate           <= 10'h000;
      end else if (ce) begin
         tx_en      <= (mode == `TOMH_MODE_ON) || (mode == `TOMH_MODE_ALT);
         rx_en      <= (mode != `TOMH_MODE_OFF);
         adsb_in_en <= (mode != `TOMH_MODE_OFF) && tgt_req_seen;
         low_power  <= (mode == `TOMH_MODE_OFF);
         alt_rpt_en <= (mode == `TOMH_MODE_ALT) && alt_avail;
         df17_en    <= (mode[1] == 1'b1) && op_q[`TOMH_F_ES];
         df11_en    <= (mode[1] == 1'b1);
         selftest_annunc <= rx_selftest_fail && (mode != `TOMH_MODE_STBY)
                            && (mode != `TOMH_MODE_OFF);
         ident_active <= (ident_cnt_q != 33'h0);
         emergency    <= op_q[`TOMH_F_EMG];
         squawk <= sel_sqk(usr_sqk_en, op_q[`TOMH_F_SQKV], op_q[`TOMH_F_SQK],
                           civ_sqk_valid, civ_sqk);
         vrate  <= op_q[`TOMH_F_VRV] ? op_q[`TOMH_F_VR] : nav_vr_q;
      end
   end

   // ***************************************
   // Interrupt status, enable and clear
   // ***************************************
   assign ev[`TOMH_IRQ_OP]    = take_op;
   assign ev[`TOMH_IRQ_NAV]   = take_nav;
   assign ev[`TOMH_IRQ_OTH]   = take & ~take_op & ~take_nav;
   assign ev[`TOMH_IRQ_IDEND] = ce & (ident_cnt_q == 33'h1) & ~take_op;
   assign ev[`TOMH_IRQ_STORE] = take_op & msg_data[`TOMH_F_PUS];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         istat_q <= '0;
      end else if (ce) begin
         // A new event wins over a clear in the same cycle
         if (rif.wr_en && rif.wr_b0 && rif.wr_addr == `TOMH_OFS_ICLR) begin
            istat_q <= (istat_q & ~rif.wr_data[`TOMH_IRQ_W-1:0]) | ev;
         end else begin
            istat_q <= istat_q | ev;
         end
      end
   end

   assign irq = |(istat_q & ien_q);

   // ***************************************
   // Register file
   // ***************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl_off_q <= `TOMH_RST_CTRL;
         ien_q      <= '0;
      end else if (ce && rif.wr_en && rif.wr_b0) begin
         if (rif.wr_addr == `TOMH_OFS_CTRL) ctrl_off_q <= rif.wr_data[0];
         if (rif.wr_addr == `TOMH_OFS_IEN) ien_q <= rif.wr_data[`TOMH_IRQ_W-1:0];
      end
   end

   always_comb begin
      rif.wr_err = !(rif.wr_addr == `TOMH_OFS_CTRL || rif.wr_addr == `TOMH_OFS_ICLR
                     || rif.wr_addr == `TOMH_OFS_IEN);
      rif.rd_err = 1'b0;
      case (rif.rd_addr)
         `TOMH_OFS_CTRL:  rif.rd_data = {31'h0, ctrl_off_q};
         `TOMH_OFS_STAT:  rif.rd_data = {13'h0, squawk, emergency, ident_active,
                                         op_q[`TOMH_F_ES], mode};
         `TOMH_OFS_ISTAT: rif.rd_data = {27'h0, istat_q};
         `TOMH_OFS_ICLR:  rif.rd_data = 32'h0000_0000;
         `TOMH_OFS_IEN:   rif.rd_data = {27'h0, ien_q};
         `TOMH_OFS_VRATE: rif.rd_data = {22'h0, vrate};
         default: begin
            rif.rd_data = 32'h0000_0000;
            rif.rd_err  = 1'b1;
         end
      endcase
   end

   tomh_axil_slv u_slv (
      .clk_sys (clk_sys),
      .srst    (srst),
      .ce      (ce),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .rif     (rif)
   );

   // ***************************************
   // Assertions
   // ***************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence s_op_take;
      take_op;
   endsequence

   a_ack_each: assert property (take |=> ack_valid && ack_type == $past(msg_type))
      else $error("message not acknowledged");
   a_off_quiet: assert property (ce && mode == `TOMH_MODE_OFF |=>
      low_power && !tx_en && !rx_en) else $error("off mode not quiet");
   a_stby_rx: assert property (ce && mode == `TOMH_MODE_STBY |=>
      !tx_en && rx_en && !df11_en) else $error("standby wrong");
   a_stby_mute: assert property (ce && mode == `TOMH_MODE_STBY |=>
      !selftest_annunc) else $error("self-test annunciated in standby");
   a_on_noalt: assert property (ce && mode == `TOMH_MODE_ON |=>
      tx_en && !alt_rpt_en) else $error("altitude sent in on mode");
   a_alt_full: assert property (ce && mode == `TOMH_MODE_ALT && alt_avail |=>
      alt_rpt_en && tx_en) else $error("altitude not reported");
   a_es_gate: assert property (ce && mode[1] && !op_q[`TOMH_F_ES]
      |=> !df17_en && df11_en) else $error("DF17 without flag");
   a_es_on: assert property (ce && mode[1] && op_q[`TOMH_F_ES] |=> df17_en)
      else $error("DF17 not enabled");
   a_store_nvm: assert property (s_op_take ##0 msg_data[`TOMH_F_PUS] |=>
      nvm_wr && nvm_wdata == $past(msg_data)) else $error("store missed");
   a_ident_run: assert property (s_op_take ##0 msg_data[`TOMH_F_IDENT] ##1 ce
      |-> ident_cnt_q == IDENT_CYC ##1 ident_active) else $error("ident not restarted");
   a_emg_take: assert property (s_op_take ##1 ce |=>
      emergency == $past(msg_data[`TOMH_F_EMG], 2)) else $error("emergency lost");
   a_sqk_dflt: assert property (ce && usr_sqk_en && !civ_sqk_valid |=>
      squawk == `TOMH_SQK_DFLT) else $error("squawk default wrong");
   a_sqk_op: assert property (ce && !usr_sqk_en && op_q[`TOMH_F_SQKV] |=>
      squawk == $past(op_q[`TOMH_F_SQK])) else $error("message squawk ignored");
   a_vr_src: assert property (ce && !op_q[`TOMH_F_VRV] |=>
      vrate == $past(nav_vr_q)) else $error("vertical rate source wrong");
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench of the operating message handler
`include "tomh_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import tomh_pkg::*;
   logic clk_sys = 0, srst = 1, ce = 1, nvm_rvalid = 0, usr_sqk_en = 0, civ_sqk_valid = 0;
   logic tgt_req_seen = 1, alt_avail = 1, rx_selftest_fail = 1, awvalid = 0, wvalid = 0;
   logic bready = 0, arvalid = 0, rready = 0;
   logic [31:0] nvm_rdata = 0, wdata = 0, nvm_wdata, rdata, msg_data, rd, wd_seen, p;
   logic [11:0] civ_sqk = 12'h456;
   logic [7:0]  awaddr = 0, araddr = 0, ack_type, msg_type, ex;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp, rr;
   logic msg_valid, msg_ready, ack_valid, nvm_wr, tx_en, rx_en, adsb_in_en, low_power, irq;
   logic alt_rpt_en, df17_en, df11_en, selftest_annunc, ident_active, acked, wr_seen;
   logic awready, wready, bvalid, arready, rvalid;
   tomh_emg_t   emergency;
   tomh_sqk_t   squawk;
   tomh_vr_t    vrate;
   int          errors = 0, compares = 0, n;
   always #2 clk_sys = ~clk_sys;
   tomh_top #(.IDENT_CYC(33'd20)) dut (.clk_sys, .srst, .ce, .msg_valid, .msg_ready, .msg_type,
      .msg_data, .ack_valid, .ack_type, .nvm_rdata, .nvm_rvalid, .nvm_wr, .nvm_wdata,
      .usr_sqk_en, .civ_sqk, .civ_sqk_valid, .tgt_req_seen, .alt_avail, .rx_selftest_fail,
      .tx_en, .rx_en, .adsb_in_en, .low_power, .alt_rpt_en, .df17_en, .df11_en,
      .selftest_annunc, .ident_active, .emergency, .squawk, .vrate, .irq, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   tomh_host_model host (.clk_sys, .msg_ready, .ack_valid, .ack_type, .msg_valid, .msg_type,
      .msg_data, .acked);
   // ****************
   // Tasks
   // ****************
   task automatic finish_test();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge clk_sys);
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      r = bresp;
      if (k == 40) begin
         errors++;
         finish_test();
      end
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge clk_sys);
         if (arready && arvalid) arvalid <= 1'b0;
         if (rvalid && !arvalid) break;
      end
      rready <= 1'b0;
      d = rdata;
      r = rresp;
      if (k == 40) begin
         errors++;
         finish_test();
      end
   endtask
   function automatic logic [31:0] op(input logic [1:0] m, input logic es, pu, id,
      input logic [2:0] e, input logic [11:0] s, input logic sv, vv, input logic [9:0] v);
      return {v, vv, sv, s, e, id, pu, es, m};
   endfunction
   task automatic snd(input logic [7:0] t, input logic [31:0] d);
      host.send(t, d);
      wr_seen = nvm_wr;
      wd_seen = nvm_wdata;
      chk(32'(acked), 32'h1);
      @(posedge clk_sys);
      #1;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask
   // ****************
   // Tests
   // ****************
   initial begin
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      tick(1);
      chk(32'({tx_en, low_power, squawk}), 32'({1'b0, 1'b1, 12'h200}));
      axr(`TOMH_OFS_STAT, rd, rr);
      chk(rd, 32'h0001_0000);
      $display("test reset done");
      for (int m = 0; m < 4; m++) begin
         snd(`TOMH_TYPE_OP, op(2'(m), 1, 0, 0, 3'h0, 12'h0, 0, 0, 10'h0));
         ex = {m > 1, m > 0, m == 0, m > 0, m == 3, m > 1, m > 1, m > 1};
         p = 32'({tx_en, rx_en, low_power, adsb_in_en, alt_rpt_en, df17_en, df11_en,
                  selftest_annunc});
         chk(p, 32'(ex));
      end
      @(posedge clk_sys) tgt_req_seen <= 1'b0;
      alt_avail <= 1'b0;
      snd(`TOMH_TYPE_OP, op(2'h3, 0, 0, 0, 3'h0, 12'h0, 0, 0, 10'h0));
      chk(32'({df17_en, df11_en, adsb_in_en, alt_rpt_en, tx_en}), 32'h9);
      @(posedge clk_sys) tgt_req_seen <= 1'b1;
      alt_avail <= 1'b1;
      snd(8'h55, 32'h0);
      $display("test modes done");
      for (int e = 0; e < 7; e++) begin
         snd(`TOMH_TYPE_OP, op(2'h2, 1, 0, 0, 3'(e), 12'h0, 0, 0, 10'h0));
         chk(32'(emergency), 32'(e));
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys) usr_sqk_en <= i[2];
         civ_sqk_valid <= i[0];
         snd(`TOMH_TYPE_OP, op(2'h2, 1, 0, 0, 3'h0, 12'h123, i[1], 0, 10'h0));
         p = i[2] ? (i[0] ? 32'h456 : 32'h200) : (i[1] ? 32'h123 : 32'h200);
         chk(32'(squawk), p);
      end
      $display("test squawk done");
      snd(`TOMH_TYPE_OP, op(2'h2, 1, 0, 0, 3'h0, 12'h0, 0, 1, 10'h155));
      snd(`TOMH_TYPE_NAV, 32'h0aa);
      chk(32'(vrate), 32'h155);
      snd(`TOMH_TYPE_OP, op(2'h2, 1, 0, 0, 3'h0, 12'h0, 0, 0, 10'h155));
      snd(`TOMH_TYPE_NAV, 32'h0aa);
      axr(`TOMH_OFS_VRATE, rd, rr);
      chk(rd, 32'h0aa);
      $display("test vrate done");
      axw(`TOMH_OFS_IEN, 32'h08, rr);
      snd(`TOMH_TYPE_OP, op(2'h2, 1, 0, 1, 3'h0, 12'h0, 0, 0, 10'h0));
      chk(32'(ident_active), 32'h1);
      // Clock enable low must freeze the ident count and the message port
      @(posedge clk_sys) ce <= 1'b0;
      tick(30);
      chk(32'({msg_ready, ident_active}), 32'h1);
      @(posedge clk_sys) ce <= 1'b1;
      tick(11);
      snd(`TOMH_TYPE_OP, op(2'h2, 1, 0, 1, 3'h0, 12'h0, 0, 0, 10'h0));
      tick(15);
      chk(32'(ident_active), 32'h1);
      for (n = 0; n < 10 && ident_active; n++) tick(1);
      chk(32'({ident_active, irq}), 32'h1);
      axw(`TOMH_OFS_ICLR, 32'h1f, rr);
      tick(2);
      chk(32'(irq), 32'h0);
      axw(`TOMH_OFS_IEN, 32'h01, rr);
      snd(`TOMH_TYPE_OP, op(2'h2, 1, 0, 0, 3'h0, 12'h0, 0, 0, 10'h0));
      chk(32'(irq), 32'h1);
      axw(`TOMH_OFS_IEN, 32'h0, rr);
      tick(2);
      axr(`TOMH_OFS_ISTAT, rd, rr);
      chk(32'({irq, rd[0]}), 32'h1);
      axw(`TOMH_OFS_STAT, 32'h0, rr);
      chk(32'(rr), 32'h2);
      axr(8'h40, rd, rr);
      chk({rd[29:0], rr}, 32'h2);
      $display("test ident irq done");
      p = op(2'h3, 1, 1, 0, 3'h0, 12'h0, 0, 0, 10'h0);
      snd(`TOMH_TYPE_OP, p);
      chk({wr_seen, wd_seen[30:0]}, {1'b1, p[30:0]});
      @(posedge clk_sys) srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      nvm_rdata <= p;
      nvm_rvalid <= 1'b1;
      @(posedge clk_sys) nvm_rvalid <= 1'b0;
      nvm_rdata <= ~p;
      tick(2);
      chk(32'({tx_en, low_power, alt_rpt_en}), 32'h5);
      axw(`TOMH_OFS_CTRL, 32'h1, rr);
      tick(1);
      chk(32'({tx_en, low_power, rr}), 32'h4);
      $display("test store done");
      finish_test();
   end
endmodule
`default_nettype wire

// ===== sim/tomh_host_model.sv
// Host model that streams messages to the handler and watches the acknowledgement
`timescale 1ns/1ns
`default_nettype none
module tomh_host_model (
   input  wire logic        clk_sys,
   input  wire logic        msg_ready,
   input  wire logic        ack_valid,
   input  wire logic [7:0]  ack_type,
   output var logic         msg_valid,
   output var logic [7:0]   msg_type,
   output var logic [31:0]  msg_data,
   output var logic         acked
);
   initial begin
      msg_valid = 1'b0;
      msg_type = 8'h00;
      msg_data = 32'h0;
      acked = 1'b0;
   end
   // Message rate compressed to at most one message every two cycles; the core keeps no time between messages
   task automatic send(input logic [7:0] t, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      msg_valid <= 1'b1;
      msg_type <= t;
      msg_data <= d;
      acked = 1'b0;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (!msg_ready && n < 20);
      msg_valid <= 1'b0;
      // Released lines show the inverse so stale data never looks valid
      msg_type <= ~t;
      msg_data <= ~d;
      #1 acked = ack_valid && (ack_type === t);
   endtask
endmodule
`default_nettype wire
